// File: inc/kefcr_pkg.sv
// Purpose: Shared constants and types for the key event queue register block
// Assumes: Eight-bit registers, two-bit register index on the link
// Notes:   Offsets, reset values, field positions and codes live here only
package kefcr_pkg;

    // Register indices
    localparam logic [1:0] REG_QUEUE    = 2'h0;
    localparam logic [1:0] REG_CONFIG   = 2'h1;
    localparam logic [1:0] REG_DEBOUNCE = 2'h2;

    // Reset values
    localparam logic [7:0] RST_CONFIG   = 8'h0a;
    localparam logic [7:0] RST_DEBOUNCE = 8'hff;

    // Queue readout codes and unmapped read value
    localparam logic [7:0] CODE_EMPTY    = 8'h3f;
    localparam logic [7:0] CODE_OVERFLOW = 8'h7f;
    localparam logic [5:0] KEY_REPEAT    = 6'h3e;
    localparam logic [4:0] KEY_TOP_PAIR  = 5'h1f;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Queue entry fields
    localparam int ENT_REPEAT  = 7;
    localparam int ENT_RELEASE = 6;

    // Configuration fields
    localparam int         CFG_RUN         = 7;
    localparam int         CFG_CLR_ON_READ = 5;
    localparam int         CFG_REL_EN      = 3;
    localparam int         CFG_WAKE_EN     = 1;
    localparam int         CFG_TMO_DIS     = 0;
    localparam logic [7:0] CFG_RSVD_MASK   = 8'h54;

    // Debounce fields
    localparam int         DEB_PORT_LSB = 5;
    localparam logic [5:0] DEB_MIN_MS   = 6'h09;

    // Queue geometry
    localparam int FIFO_DEPTH = 16;
    localparam int PTR_W      = 4;

    typedef enum logic [1:0] {
        KEFCR_H_IDLE = 2'b00,
        KEFCR_H_SEND = 2'b01
    } kefcr_hstate_t;

endpackage

// File: inc/kefcr_link_if.sv
// Purpose: Link between the host end and the key event device
// Assumes: Host makes link_clk; device samples on its rising edge
// Notes:   Host moves sel only while link_clk falls; addr, write and wdata load on any clock edge
`timescale 1ns/1ps
`default_nettype none
interface kefcr_link_if;
    logic       link_clk;
    logic       sel;
    logic       write;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       rvalid;

    modport host_end (output link_clk, sel, write, addr, wdata, input rdata, rvalid);
    modport dev_end  (input link_clk, sel, write, addr, wdata, output rdata, rvalid);
endinterface
`default_nettype wire

// File: rtl/kefcr_device.sv
// Purpose: Key event queue, configuration and debounce registers
// Assumes: Whole block runs on link_clk; event inputs are asynchronous
// Notes:   Key fields must be stable before key_toggle changes
`timescale 1ns/1ps
`default_nettype none
module kefcr_device (
    kefcr_link_if.dev_end   link,                   // Register link, device side
    input  wire logic       sys_rst,                // Reset, high, from system domain
    input  wire logic       key_toggle,             // Toggles once per key event
    input  wire logic [5:0] key_number,             // Debounced key number
    input  wire logic       key_release,            // Event is a release
    input  wire logic       key_repeat,             // Event is an autorepeat
    input  wire logic       autosleep_req,          // Rising edge forces sleep
    output logic            int_n,                  // Interrupt, low active
    output logic            run_mode,               // High when operating
    output logic            release_detect_en,      // Release events enabled
    output logic            bus_timeout_dis,        // Bus timeout disabled
    output logic [5:0]      debounce_ms,            // Debounce cycle in ms
    output logic [5:0]      general_output_line_en  // Columns 7..2 used as outputs
);
    import kefcr_pkg::*;

    logic              rst_meta;
    logic              rst_link;
    logic              tog_meta;
    logic              tog_sync;
    logic              tog_prev;
    logic              slp_meta;
    logic              slp_sync;
    logic              slp_prev;
    logic [7:0]        key_meta;
    logic [7:0]        key_sync;
    logic [7:0]        cfg;
    logic [7:0]        deb;
    logic [7:0]        mem [FIFO_DEPTH];
    logic [PTR_W-1:0]  wr_ptr;
    logic [PTR_W-1:0]  rd_ptr;
    logic [PTR_W:0]    count;
    logic              overflow;
    logic              ev_pulse;
    logic              sleep_pulse;
    logic              accept;
    logic              full;
    logic              rd_any;
    logic              rd_queue;
    logic              wr_cfg;
    logic              wr_deb;
    logic              pop;
    logic              push;
    logic              ovf_set;
    logic              wake;
    logic              int_clear;
    logic [7:0]        next_queue_view;

    // Column output allocation, nested from column 7 downward
    function automatic logic [5:0] port_decode(input logic [2:0] code);
        logic [5:0] m;
        m = 6'h00;
        case (code)
            3'b000:  m = 6'h00;
            3'b001:  m = 6'h20;
            3'b010:  m = 6'h30;
            3'b011:  m = 6'h38;
            3'b100:  m = 6'h3c;
            3'b101:  m = 6'h3e;
            default: m = 6'h3f;
        endcase
        return m;
    endfunction

    // Two-stage synchronisers
    always_ff @(posedge link.link_clk) begin
        rst_meta <= sys_rst;
        rst_link <= rst_meta;
        tog_meta <= key_toggle;
        tog_sync <= tog_meta;
        slp_meta <= autosleep_req;
        slp_sync <= slp_meta;
        key_meta <= {key_repeat, key_release, key_number};
        key_sync <= key_meta;
    end

    always_ff @(posedge link.link_clk) begin
        if (rst_link) begin
            tog_prev <= 1'b0;
            slp_prev <= 1'b0;
        end else begin
            tog_prev <= tog_sync;
            slp_prev <= slp_sync;
        end
    end

    assign ev_pulse    = !rst_link && (tog_sync != tog_prev);
    assign sleep_pulse = !rst_link && slp_sync && !slp_prev;

    assign rd_any   = link.sel && !link.write;
    assign rd_queue = rd_any && (link.addr == REG_QUEUE);
    assign wr_cfg   = link.sel && link.write && (link.addr == REG_CONFIG);
    assign wr_deb   = link.sel && link.write && (link.addr == REG_DEBOUNCE);

    assign full     = (count == (PTR_W+1)'(FIFO_DEPTH));
    assign pop      = rd_queue && !overflow && (count != '0);
    assign accept   = ev_pulse && (!key_sync[ENT_RELEASE] || key_sync[ENT_REPEAT]
                      || cfg[CFG_REL_EN]);
    assign push     = accept && (!full || pop);
    assign ovf_set  = accept && full && !pop;
    assign wake     = accept && !key_sync[ENT_RELEASE] && !key_sync[ENT_REPEAT]
                      && cfg[CFG_WAKE_EN] && !cfg[CFG_RUN];
    assign int_clear = cfg[CFG_CLR_ON_READ] ? rd_queue
                       : ((count == '0) && !overflow);

    // Queue storage and pointers
    always_ff @(posedge link.link_clk) begin
        if (push) begin
            mem[wr_ptr] <= key_sync;
        end
    end

    always_ff @(posedge link.link_clk) begin
        if (rst_link) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

    // Overflow reported once ahead of the remaining entries
    always_ff @(posedge link.link_clk) begin
        if (rst_link) begin
            overflow <= 1'b0;
        end else if (ovf_set) begin
            overflow <= 1'b1;
        end else if (rd_queue) begin
            overflow <= 1'b0;
        end
    end

    // Queue readout encoding
    always_comb begin
        logic [7:0] ent;
        logic       more;
        ent  = mem[rd_ptr];
        more = (count > (PTR_W+1)'(1));
        if (overflow) begin
            next_queue_view = CODE_OVERFLOW;
        end else if (count == '0) begin
            next_queue_view = CODE_EMPTY;
        end else if (ent[ENT_REPEAT]) begin
            next_queue_view = {1'b0, more, KEY_REPEAT};
        end else if (ent[5:1] == KEY_TOP_PAIR) begin
            next_queue_view = {1'b1, ent[ENT_RELEASE], ent[5:0]};
        end else begin
            next_queue_view = {more, ent[ENT_RELEASE], ent[5:0]};
        end
    end

    // Configuration; hardware sleep and wake win over a host write
    always_ff @(posedge link.link_clk) begin
        if (rst_link) begin
            cfg <= RST_CONFIG;
        end else begin
            if (wr_cfg) begin
                cfg <= link.wdata & ~CFG_RSVD_MASK;
            end
            if (sleep_pulse) begin
                cfg[CFG_RUN] <= 1'b0;
            end else if (wake) begin
                cfg[CFG_RUN] <= 1'b1;
            end
        end
    end

    always_ff @(posedge link.link_clk) begin
        if (rst_link) begin
            deb <= RST_DEBOUNCE;
        end else if (wr_deb) begin
            deb <= link.wdata;
        end
    end

    // Interrupt; a new event wins over a clear
    always_ff @(posedge link.link_clk) begin
        if (rst_link) begin
            int_n <= 1'b1;
        end else if (push || ovf_set) begin
            int_n <= 1'b0;
        end else if (int_clear) begin
            int_n <= 1'b1;
        end
    end

    // Read answer
    always_ff @(posedge link.link_clk) begin
        if (rst_link) begin
            link.rdata  <= '0;
            link.rvalid <= 1'b0;
        end else begin
            link.rvalid <= rd_any;
            if (rd_any) begin
                case (link.addr)
                    REG_QUEUE:    link.rdata <= next_queue_view;
                    REG_CONFIG:   link.rdata <= cfg;
                    REG_DEBOUNCE: link.rdata <= deb;
                    default:      link.rdata <= READ_UNMAPPED;
                endcase
            end
        end
    end

    // Registered control outputs
    always_ff @(posedge link.link_clk) begin
        if (rst_link) begin
            run_mode               <= 1'b0;
            release_detect_en      <= 1'b0;
            bus_timeout_dis        <= 1'b0;
            debounce_ms            <= DEB_MIN_MS;
            general_output_line_en <= '0;
        end else begin
            run_mode               <= cfg[CFG_RUN];
            release_detect_en      <= cfg[CFG_REL_EN];
            bus_timeout_dis        <= cfg[CFG_TMO_DIS];
            debounce_ms            <= DEB_MIN_MS + {1'b0, deb[DEB_PORT_LSB-1:0]};
            general_output_line_en <= port_decode(deb[7:DEB_PORT_LSB]);
        end
    end

endmodule
`default_nettype wire

// File: rtl/kefcr_host.sv
// Purpose: Host end issuing register reads and writes over the link
// Assumes: link_clk is clock divided by two, made here
// Notes:   One request in flight; sel moves only on a falling link edge, addr, write and wdata on any clock
`timescale 1ns/1ps
`default_nettype none
module kefcr_host (
    input  wire logic          clock,        // System clock
    input  wire logic          sys_rst,      // Synchronous reset, high
    input  wire logic          cmd_valid,    // Request present
    input  wire logic          cmd_write,    // High for write
    input  wire logic [1:0]    cmd_addr,     // Register index
    input  wire logic [7:0]    cmd_wdata,    // Write data
    output logic               cmd_ready,    // Request taken when high with valid
    output logic               rsp_valid,    // Read data pulse
    output logic [7:0]         rsp_data,     // Read data
    kefcr_link_if.host_end      link          // Register link, host side
);
    import kefcr_pkg::*;

    kefcr_hstate_t state;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link.link_clk <= 1'b0;
        end else begin
            link.link_clk <= ~link.link_clk;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state      <= KEFCR_H_IDLE;
            cmd_ready  <= 1'b1;
            rsp_valid  <= 1'b0;
            rsp_data   <= '0;
            link.sel   <= 1'b0;
            link.write <= 1'b0;
            link.addr  <= '0;
            link.wdata <= '0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                KEFCR_H_IDLE: begin
                    if (cmd_valid) begin
                        cmd_ready  <= 1'b0;
                        link.write <= cmd_write;
                        link.addr  <= cmd_addr;
                        if (cmd_addr == REG_CONFIG) begin
                            link.wdata <= cmd_wdata & ~CFG_RSVD_MASK;
                        end else begin
                            link.wdata <= cmd_wdata;
                        end
                        state <= KEFCR_H_SEND;
                    end
                end
                KEFCR_H_SEND: begin
                    if (link.link_clk && !link.sel) begin
                        link.sel <= 1'b1;
                    end else if (link.link_clk && link.sel) begin
                        link.sel  <= 1'b0;
                        cmd_ready <= 1'b1;
                        state     <= KEFCR_H_IDLE;
                        if (!link.write && link.rvalid) begin
                            rsp_valid <= 1'b1;
                            rsp_data  <= link.rdata;
                        end
                    end
                end
                default: begin
                    state     <= KEFCR_H_IDLE;
                    cmd_ready <= 1'b1;
                    link.sel  <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// File: test/kefcr_assertions.sv
// Purpose: Link-level checks between host end and key event device
// Assumes: Everything sampled on the link clock rise
// Notes:   Shadows follow host writes so readback can be judged
`timescale 1ns/1ps
`default_nettype none
module kefcr_assertions
    import kefcr_pkg::*;
(
    input wire logic       link_clk, // Link clock
    input wire logic       dev_rst,  // Device reset
    input wire logic       sel,      // Request strobe
    input wire logic       write,    // Write request
    input wire logic [1:0] addr,     // Register index
    input wire logic [7:0] wdata,    // Write data
    input wire logic [7:0] rdata,    // Read data
    input wire logic       rvalid    // Read answer
);
    logic [7:0] cfg_seen;
    logic [7:0] deb_seen;

    default clocking @(posedge link_clk); endclocking
    default disable iff (dev_rst);

    always_ff @(posedge link_clk) begin
        if (dev_rst)
            cfg_seen <= RST_CONFIG;
        else if (sel && write && addr == REG_CONFIG)
            cfg_seen <= wdata & ~CFG_RSVD_MASK;
    end

    always_ff @(posedge link_clk) begin
        if (dev_rst)
            deb_seen <= RST_DEBOUNCE;
        else if (sel && write && addr == REG_DEBOUNCE)
            deb_seen <= wdata;
    end

    read_answered_a:
        assert property (sel && !write |=> rvalid) else $error("Read not answered");
    answer_cause_a:
        assert property (rvalid |-> $past(sel && !write)) else $error("Answer without read");
    write_silent_a:
        assert property (sel && write |=> !rvalid) else $error("Write gave an answer");
    rdata_hold_a:
        assert property (!$past(sel && !write) |-> $stable(rdata)) else $error("Read data moved");
    unmapped_zero_a:
        assert property (sel && !write && addr == 2'h3 |=> rdata == READ_UNMAPPED)
        else $error("Unmapped read not zero");
    reserved_zero_a:
        assert property (rvalid && $past(addr) == REG_CONFIG |-> (rdata & CFG_RSVD_MASK) == 8'h00)
        else $error("Reserved config bits set");
    reserved_write_a:
        assert property (sel && write && addr == REG_CONFIG |-> (wdata & CFG_RSVD_MASK) == 8'h00)
        else $error("Reserved config bits written");
    config_readback_a:
        assert property (rvalid && $past(addr) == REG_CONFIG |-> rdata[5:0] == cfg_seen[5:0])
        else $error("Config readback wrong");
    debounce_readback_a:
        assert property (rvalid && $past(addr) == REG_DEBOUNCE |-> rdata == deb_seen)
        else $error("Debounce readback wrong");
endmodule
`default_nettype wire

// File: test/test_keypad_event_fifo_config_regs.sv
// Purpose: Self-checking bench for host and key event device on one link
// Assumes: Host makes link_clk; device reset outlasts host reset to see link edges
// Notes:   Queue model in integers predicts every queue readback
`timescale 1ns/1ps
`default_nettype none
module test_keypad_event_fifo_config_regs;
    import kefcr_pkg::*;
    logic       clock = 1'b0, sys_rst = 1'b1, dev_rst = 1'b1;
    logic       cmd_valid = 1'b0, cmd_write = 1'b0, autosleep_req = 1'b0;
    logic       key_toggle = 1'b0, key_release = 1'b0, key_repeat = 1'b0;
    logic [1:0] cmd_addr = 2'h0;
    logic [7:0] cmd_wdata = 8'h00, rsp_data, got;
    logic [5:0] key_number = 6'h00, debounce_ms, gol_en;
    logic       cmd_ready, rsp_valid, int_n, run_mode, rel_en, tmo_dis;
    logic [7:0] cfg = RST_CONFIG, deb = RST_DEBOUNCE;
    int         fail_count = 0, comparisons = 0, cycles = 0, seed = 32'h109e7c63;
    int         q[$];
    bit         ovf = 1'b0;
    kefcr_link_if link ();

    kefcr_host kefcr_host_inst (.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .link(link));
    kefcr_device kefcr_device_inst (.link(link), .sys_rst(dev_rst), .key_toggle(key_toggle),
        .key_number(key_number), .key_release(key_release), .key_repeat(key_repeat),
        .autosleep_req(autosleep_req), .int_n(int_n), .run_mode(run_mode),
        .release_detect_en(rel_en), .bus_timeout_dis(tmo_dis), .debounce_ms(debounce_ms),
        .general_output_line_en(gol_en));
    kefcr_assertions kefcr_assertions_inst (.link_clk(link.link_clk), .dev_rst(dev_rst),
        .sel(link.sel), .write(link.write), .addr(link.addr), .wdata(link.wdata),
        .rdata(link.rdata), .rvalid(link.rvalid));

    always #25 clock = ~clock;

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic xfer(input logic w, input logic [1:0] a, input logic [7:0] d);
        int n;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr  <= a;
        cmd_wdata <= d;
        @(posedge clock);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (cmd_ready !== 1'b1 && n < 40);
        chk("cmd_ready", 8'h01, 8'(cmd_ready));
        got = rsp_data;
        if (!w)
            chk("rsp_valid", 8'h01, 8'(rsp_valid));
    endtask

    task automatic rdchk(input string name, input logic [1:0] a, input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(name, exp, got);
    endtask

    // Pops the model like the device: overflow once, then entries, then empty
    task automatic rdq();
        logic [7:0] e;
        int         v;
        if (ovf) begin
            e = CODE_OVERFLOW;
            ovf = 1'b0;
        end else if (q.size() == 0) begin
            e = CODE_EMPTY;
        end else begin
            v = q.pop_front();
            if (v[7])
                e = {1'b0, q.size() > 0, KEY_REPEAT};
            else if (v[5:1] == KEY_TOP_PAIR)
                e = {1'b1, v[6], v[5:0]};
            else
                e = {q.size() > 0, v[6], v[5:0]};
        end
        rdchk("queue", REG_QUEUE, e);
    endtask

    task automatic ev(input logic [5:0] k, input logic r, input logic rp);
        @(posedge clock);
        key_number  <= k;
        key_release <= r;
        key_repeat  <= rp;
        repeat (9) @(posedge clock);
        key_toggle <= ~key_toggle;
        repeat (9) @(posedge clock);
        if (r && !cfg[CFG_REL_EN])
            return;
        if (!r && !rp && cfg[CFG_WAKE_EN])
            cfg[CFG_RUN] = 1'b1;
        if (q.size() == FIFO_DEPTH)
            ovf = 1'b1;
        else
            q.push_back({rp, r, k});
    endtask

    task automatic outs();
        int n;
        n = deb[7:6] == 2'b11 ? 6 : int'(deb[7:5]);
        chk("run_mode", 8'(cfg[CFG_RUN]), 8'(run_mode));
        chk("release_en", 8'(cfg[CFG_REL_EN]), 8'(rel_en));
        chk("timeout_dis", 8'(cfg[CFG_TMO_DIS]), 8'(tmo_dis));
        chk("debounce_ms", 8'h09 + 8'(deb[4:0]), 8'(debounce_ms));
        chk("gpo_en", 8'(6'h3f & ~(6'h3f >> n)), 8'(gol_en));
    endtask

    task automatic wcfg(input logic [7:0] d);
        cfg = d & ~CFG_RSVD_MASK;
        xfer(1'b1, REG_CONFIG, d);
        repeat (4) @(posedge clock);
        outs();
    endtask

    initial begin
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clock);
        dev_rst <= 1'b0;
        repeat (12) @(posedge clock);
        outs();
        rdchk("config", REG_CONFIG, RST_CONFIG);
        rdchk("debounce", REG_DEBOUNCE, RST_DEBOUNCE);
        xfer(1'b1, REG_QUEUE, 8'h12);
        rdq();
        rdchk("unmapped", 2'h3, READ_UNMAPPED);
        for (int i = 0; i < 8; i++) begin
            deb = {3'(i), 5'(i * 31 / 7)};
            xfer(1'b1, REG_DEBOUNCE, deb);
            rdchk("debounce", REG_DEBOUNCE, deb);
            wcfg(8'($random(seed)));
            rdchk("config", REG_CONFIG, cfg);
        end
        wcfg(8'h88);
        ev(6'h3e, 1'b0, 1'b0);
        ev(6'h3f, 1'b1, 1'b0);
        ev(6'h00, 1'b0, 1'b1);
        chk("int_n", 8'h00, 8'(int_n));
        for (int i = 0; i < 3; i++)
            ev(6'($unsigned($random(seed)) % 62), 1'($random(seed)), 1'b0);
        repeat (7) rdq();
        repeat (4) @(posedge clock);
        chk("int_n", 8'h01, 8'(int_n));
        for (int i = 0; i < 17; i++)
            ev(6'(i), 1'b0, 1'b0);
        repeat (18) rdq();
        wcfg(8'ha8);
        ev(6'h01, 1'b0, 1'b0);
        ev(6'h02, 1'b1, 1'b0);
        rdq();
        repeat (4) @(posedge clock);
        chk("int_n", 8'h01, 8'(int_n));
        repeat (2) rdq();
        wcfg(8'h02);
        ev(6'h07, 1'b1, 1'b0);
        ev(6'h08, 1'b0, 1'b0);
        repeat (4) @(posedge clock);
        chk("run_mode", 8'h01, 8'(run_mode));
        rdchk("config", REG_CONFIG, cfg);
        repeat (2) rdq();
        autosleep_req <= 1'b1;
        repeat (6) @(posedge clock);
        autosleep_req <= 1'b0;
        repeat (6) @(posedge clock);
        chk("run_mode", 8'h00, 8'(run_mode));
        cfg[CFG_RUN] = 1'b0;
        rdchk("config", REG_CONFIG, cfg);
        final_report();
    end
endmodule
`default_nettype wire
